//--- hw/tqo_pkg.sv
// Constants for the two-phase / one-shot timer channel.
// Assumes a 20 MHz clk_sys and a simple strobe register port.
//
// Overview of operation
// (R1) Two-phase counting begins when software sets the count start flag.
// (R2) Two-phase counting halts when software clears the count start flag.
// (R3) Two-phase counter overflow or underflow raises an interrupt request.
// (R4) On overflow or underflow the counter reloads and keeps counting.
// (R5) Timer register read returns the count; two-phase only on channels 2-4.
// (R6) Timer write while stopped loads both reload register and counter.
// (R7) Timer write while counting loads only the reload register.
// (R8) Normal mode: input rise counts up, fall counts down, other pin high.
// (R9) Times four: input rising with other pin high counts up every edge.
// (R10) Times four: input falling with other pin high counts down every edge.
// (R11) One-shot counts down, reloads at zero, then stops.
// (R12) One-shot trigger while running reloads and restarts the count.
// (R13) One-shot starts on an external trigger edge when selected.
// (R14) One-shot starts on the other timer's overflow when selected.
// (R15) One-shot starts when software sets the one-shot start flag.
// (R16) One-shot stops at once when the count start flag is cleared.
// (R17) One-shot raises an interrupt request when the count reaches zero.
// (R18) One-shot input pin is a general port or the trigger input.
// (R19) One-shot output pin is a general port or the running pulse.
// (R20) One-shot timer register read is undefined; software must ignore it.
// (R21) One-shot count source is the clock divided by 1, 8 or 32.
// (R22) A channel setting picks normal/times-four or the trigger source; channel 4 is always times-four, whatever the setting.

package tqo_pkg;
	// ************************************************
	// Register map
	// ************************************************
	localparam logic [3:0] ADDR_CTRL   = 4'h0;
	localparam logic [3:0] ADDR_TIMER  = 4'h4;
	localparam logic [3:0] ADDR_STATUS = 4'h8;
	localparam logic [3:0] ADDR_PORT   = 4'hC;

	// ************************************************
	// Control fields
	// ************************************************
	localparam int CTRL_START    = 0;  // Count start flag
	localparam int CTRL_SHOT     = 1;  // One-shot start, write-one pulse
	localparam int CTRL_MODE     = 2;  // 0 two-phase, 1 one-shot
	localparam int CTRL_X4       = 3;  // Two-phase times-four
	localparam int CTRL_TRIG_LO  = 4;  // Trigger source, 2 bits
	localparam int CTRL_SRC_LO   = 6;  // Count source, 2 bits
	localparam int CTRL_INTRIG   = 8;  // Input pin is trigger
	localparam int CTRL_OUTPULSE = 9;  // Output pin is pulse
	localparam int CTRL_TRIGFALL = 10; // Trigger on falling edge
	localparam int CTRL_WIDTH    = 11;
	localparam logic [10:0] CTRL_RESET = 11'h000;

	localparam logic [1:0] TRIG_SW    = 2'h0;
	localparam logic [1:0] TRIG_PIN   = 2'h1;
	localparam logic [1:0] TRIG_OTHER = 2'h2;
	localparam logic [1:0] SRC_DIV1   = 2'h0;
	localparam logic [1:0] SRC_DIV8   = 2'h1;
	localparam logic [1:0] SRC_DIV32  = 2'h2;
	localparam int PORT_OUT = 0; // General port output latch
	localparam int PORT_DIR = 1; // General port drive enable

	// ************************************************
	// Counter and prescaler
	// ************************************************
	localparam logic [15:0] CNT_MAX    = 16'hFFFF;
	localparam logic [15:0] CNT_ZERO   = 16'h0000;
	localparam logic [15:0] CNT_RESET  = 16'h0000;
	localparam logic [4:0]  PRE_LAST8  = 5'h07;
	localparam logic [4:0]  PRE_LAST32 = 5'h1F;

	typedef enum logic [1:0] {
		ST_STOP  = 2'b00,
		ST_EVENT = 2'b01,
		ST_WAIT  = 2'b10,
		ST_RUN   = 2'b11
	} tqo_state_t;
endpackage : tqo_pkg

//--- hw/tqo_timer.sv
// One 16-bit timer channel: two-phase event counter and one-shot timer.
// Assumes pins are asynchronous; register port and trigger input on clk_sys.
`timescale 1ns/1ps

module tqo_timer
	import tqo_pkg::*;
#(
	parameter int CHANNEL = 2
) (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	// Register port
	input  wire logic [3:0]  regAddr,
	input  wire logic [15:0] regWdata,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic      [15:0] regRdata,
	// Other timer overflow, one-cycle pulse
	input  wire logic        otherOvf,
	// Pins
	input  wire logic        timerInputPin,
	input  wire logic        timerOutputPinIn,
	output logic             timerOutputPinOut,
	output logic             timerOutputPinOe,
	// Interrupt request, one-cycle pulse
	output logic             irqReq
);

	// ************************************************
	// Decoding helpers
	// ************************************************
	// Gray position of the two pins
	function automatic logic [1:0] quadPos(input logic a, input logic b);
		quadPos = {a, a ^ b};
	endfunction : quadPos

	function automatic logic isAddr(input logic [3:0] a, input logic [3:0] k);
		isAddr = (a == k);
	endfunction : isAddr

	// ************************************************
	// Pin synchronisers
	// ************************************************
	logic [1:0] inSync;
	logic [1:0] outSync;
	logic       inPrev;
	logic       outPrev;

	// Two flops per pin, then a history flop
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			inSync  <= 2'b00;
			outSync <= 2'b00;
			inPrev  <= 1'b0;
			outPrev <= 1'b0;
		end else begin
			inSync  <= {inSync[0], timerInputPin};
			outSync <= {outSync[0], timerOutputPinIn};
			inPrev  <= inSync[1];
			outPrev <= outSync[1];
		end
	end

	wire pinA = inSync[1];
	wire pinB = outSync[1];
	wire aRise = pinA & ~inPrev;
	wire aFall = ~pinA & inPrev;

	// ************************************************
	// Control register and prescaler
	// ************************************************
	logic [CTRL_WIDTH-1:0] ctrl_reg;
	logic                  shotStart_reg;
	logic                  portOut_reg;
	logic                  portDir_reg;
	logic [4:0]            pre_reg;

	wire wrCtrl  = regWr & isAddr(regAddr, ADDR_CTRL);
	wire wrTimer = regWr & isAddr(regAddr, ADDR_TIMER);
	wire wrPort  = regWr & isAddr(regAddr, ADDR_PORT);
	wire startFlag = ctrl_reg[CTRL_START];
	wire shotMode  = ctrl_reg[CTRL_MODE];
	wire x4Mode    = ctrl_reg[CTRL_X4] | (CHANNEL == 4);
	wire [1:0] trigSel = ctrl_reg[CTRL_TRIG_LO +: 2];
	wire [1:0] srcSel  = ctrl_reg[CTRL_SRC_LO +: 2];
	wire twoPhaseOk = (CHANNEL >= 2) && (CHANNEL <= 4); // [R5]

	// Control bits written by software
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			ctrl_reg <= CTRL_RESET;
		end else if (wrCtrl) begin
			ctrl_reg <= regWdata[CTRL_WIDTH-1:0]; // [R1] [R2] [R22]
		end
	end

	// One-shot start flag, pulse for one cycle
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			shotStart_reg <= 1'b0;
		end else begin
			shotStart_reg <= wrCtrl & regWdata[CTRL_SHOT];
		end
	end

	// General port output latch and direction
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			portOut_reg <= 1'b0;
			portDir_reg <= 1'b0;
		end else if (wrPort) begin
			portOut_reg <= regWdata[PORT_OUT];
			portDir_reg <= regWdata[PORT_DIR];
		end
	end

	// Free running prescaler
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pre_reg <= 5'h00;
		end else begin
			pre_reg <= pre_reg + 5'h01;
		end
	end

	// Prescaled clock enables: divide by 1 always high, divide by 8 and 32 one-cycle pulses
	wire prescaledClockDiv1  = 1'b1;
	wire prescaledClockDiv8  = (pre_reg[2:0] == PRE_LAST8[2:0]);
	wire prescaledClockDiv32 = (pre_reg == PRE_LAST32);

	// Count source tick
	logic tick;
	always_comb begin
		case (srcSel)
			SRC_DIV1:  tick = prescaledClockDiv1; // [R21]
			SRC_DIV8:  tick = prescaledClockDiv8;
			SRC_DIV32: tick = prescaledClockDiv32;
			default:   tick = prescaledClockDiv1;
		endcase
	end

	// ************************************************
	// Two-phase decoder
	// ************************************************
	logic up;
	logic down;
	logic [1:0] posDiff;
	always_comb begin
		posDiff = quadPos(pinA, pinB) - quadPos(inPrev, outPrev);
		if (x4Mode) begin
			up   = (posDiff == 2'd1); // [R9]
			down = (posDiff == 2'd3); // [R10]
		end else begin
			up   = aRise & pinB; // [R8]
			down = aFall & pinB; // [R8]
		end
	end

	// ************************************************
	// Triggers and state
	// ************************************************
	tqo_state_t state_reg;
	tqo_state_t state_next;
	logic [15:0] cnt_reg;
	logic [15:0] reload_reg;
	logic        trig;
	logic        pinTrig;

	wire running = (state_reg == ST_EVENT) || (state_reg == ST_RUN);
	wire shotEnd = (state_reg == ST_RUN) && tick && (cnt_reg <= 16'h0001);
	wire wrap = (state_reg == ST_EVENT) &&
		((up && cnt_reg == CNT_MAX) || (down && cnt_reg == CNT_ZERO));

	always_comb begin
		pinTrig = ctrl_reg[CTRL_TRIGFALL] ? aFall : aRise;
		case (trigSel)
			TRIG_PIN:   trig = pinTrig & ctrl_reg[CTRL_INTRIG]; // [R13] [R18]
			TRIG_OTHER: trig = otherOvf; // [R14]
			default:    trig = 1'b0;
		endcase
		trig = trig | shotStart_reg; // [R15]
	end

	// Next state
	always_comb begin
		state_next = state_reg;
		if (!startFlag) begin
			state_next = ST_STOP; // [R2] [R16]
		end else if (!shotMode) begin
			state_next = twoPhaseOk ? ST_EVENT : ST_STOP; // [R1]
		end else if (trig) begin
			state_next = ST_RUN; // [R12]
		end else if (shotEnd) begin
			state_next = ST_WAIT; // [R11]
		end else if (state_reg != ST_RUN) begin
			state_next = ST_WAIT;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state_reg <= ST_STOP;
		end else begin
			state_reg <= state_next;
		end
	end

	// Reload register
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			reload_reg <= CNT_RESET;
		end else if (wrTimer) begin
			reload_reg <= regWdata; // [R6] [R7]
		end
	end

	// Counter
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			cnt_reg <= CNT_RESET;
		end else if (wrTimer && !running) begin
			cnt_reg <= regWdata; // [R6]
		end else if (state_reg == ST_EVENT) begin
			if (wrap) begin
				cnt_reg <= reload_reg; // [R4] [R7]
			end else if (up) begin
				cnt_reg <= cnt_reg + 16'h0001;
			end else if (down) begin
				cnt_reg <= cnt_reg - 16'h0001;
			end
		end else if (shotMode && startFlag && trig) begin
			cnt_reg <= reload_reg; // [R12] [R15]
		end else if (shotEnd) begin
			cnt_reg <= reload_reg; // [R11]
		end else if (state_reg == ST_RUN && tick) begin
			cnt_reg <= cnt_reg - 16'h0001; // [R11] [R21]
		end
	end

	// Interrupt request pulse
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			irqReq <= 1'b0;
		end else begin
			irqReq <= wrap | (shotEnd & startFlag & ~trig); // [R3] [R17]
		end
	end

	// ************************************************
	// Output pin
	// ************************************************
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			timerOutputPinOut <= 1'b0;
			timerOutputPinOe  <= 1'b0;
		end else begin
			timerOutputPinOe <= shotMode & (ctrl_reg[CTRL_OUTPULSE] | portDir_reg);
			timerOutputPinOut <= ctrl_reg[CTRL_OUTPULSE] ?
				(state_next == ST_RUN) : portOut_reg; // [R19]
		end
	end

	// ************************************************
	// Read port
	// ************************************************
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			regRdata <= 16'h0000;
		end else if (!regRd) begin
			regRdata <= 16'h0000;
		end else begin
			case (regAddr)
				ADDR_CTRL:   regRdata <= {5'h00, ctrl_reg};
				ADDR_TIMER:  regRdata <= cnt_reg; // [R5] [R20]
				ADDR_STATUS: regRdata <= {14'h0000, state_reg};
				ADDR_PORT:   regRdata <= {12'h000, portDir_reg, portOut_reg, pinB, pinA};
				default:     regRdata <= 16'h0000;
			endcase
		end
	end

	// ************************************************
	// Assertions
	// ************************************************
	// Step decode from the raw pin history, apart from the counter logic
	wire aMoved  = (pinA != inPrev) && (pinB == outPrev);
	wire bMoved  = (pinB != outPrev) && (pinA == inPrev);
	wire fwdStep = (aMoved && (pinA == pinB)) || (bMoved && (pinA != pinB));
	wire revStep = (aMoved && (pinA != pinB)) || (bMoved && (pinA == pinB));

	property p_wrap_reload;
		@(posedge clk_sys) disable iff (sys_rst)
		(wrap && !wrTimer) |=> (cnt_reg == $past(reload_reg)) && irqReq;
	endproperty
	a_wrap_reload: assert property (p_wrap_reload) // [R3] [R4]
		else $error("wrap did not reload or raise request");

	property p_event_start;
		@(posedge clk_sys) disable iff (sys_rst)
		(wrCtrl && regWdata[CTRL_START] && !regWdata[CTRL_MODE])
			|=> ##1 (state_reg == ST_EVENT);
	endproperty
	a_event_start: assert property (p_event_start) // [R1]
		else $error("two-phase count did not start");

	property p_stop;
		@(posedge clk_sys) disable iff (sys_rst)
		(wrCtrl && !regWdata[CTRL_START]) |=> ##1 (state_reg == ST_STOP);
	endproperty
	a_stop: assert property (p_stop) // [R2] [R16]
		else $error("clearing start flag did not stop");

	property p_wr_stopped;
		@(posedge clk_sys) disable iff (sys_rst)
		(wrTimer && !running) |=> (cnt_reg == $past(regWdata))
			&& (reload_reg == $past(regWdata));
	endproperty
	a_wr_stopped: assert property (p_wr_stopped) // [R6]
		else $error("stopped write missed counter");

	property p_wr_running;
		@(posedge clk_sys) disable iff (sys_rst)
		(wrTimer && state_reg == ST_EVENT && !up && !down) |=> $stable(cnt_reg);
	endproperty
	a_wr_running: assert property (p_wr_running) // [R7]
		else $error("running write touched counter");

	property p_normal_up;
		@(posedge clk_sys) disable iff (sys_rst)
		(state_reg == ST_EVENT && !x4Mode && aRise && pinB && !wrap)
			|=> cnt_reg == $past(cnt_reg) + 16'h0001;
	endproperty
	a_normal_up: assert property (p_normal_up) // [R8]
		else $error("normal mode missed up count");

	property p_shot_end;
		@(posedge clk_sys) disable iff (sys_rst)
		(shotEnd && startFlag && !trig && shotMode)
			|=> irqReq && state_reg == ST_WAIT && cnt_reg == $past(reload_reg);
	endproperty
	a_shot_end: assert property (p_shot_end) // [R11] [R17]
		else $error("one-shot end wrong");

	property p_shot_trig;
		@(posedge clk_sys) disable iff (sys_rst)
		(shotMode && startFlag && trig && !wrCtrl && !wrTimer)
			|=> state_reg == ST_RUN && cnt_reg == $past(reload_reg);
	endproperty
	a_shot_trig: assert property (p_shot_trig) // [R12] [R13] [R15]
		else $error("trigger did not start one-shot");

	property p_pulse;
		@(posedge clk_sys) disable iff (sys_rst)
		(shotMode && ctrl_reg[CTRL_OUTPULSE]) ##1 $stable(ctrl_reg)
			|-> timerOutputPinOut == (state_reg == ST_RUN);
	endproperty
	a_pulse: assert property (p_pulse) // [R19]
		else $error("pulse output not tracking run");

	property p_x4_up;
		@(posedge clk_sys) disable iff (sys_rst)
		(state_reg == ST_EVENT && x4Mode && fwdStep && cnt_reg != CNT_MAX)
			|=> cnt_reg == $past(cnt_reg) + 16'h0001;
	endproperty
	a_x4_up: assert property (p_x4_up) // [R9]
		else $error("times-four mode missed up count");

	property p_x4_down;
		@(posedge clk_sys) disable iff (sys_rst)
		(state_reg == ST_EVENT && x4Mode && revStep && cnt_reg != CNT_ZERO)
			|=> cnt_reg == $past(cnt_reg) - 16'h0001;
	endproperty
	a_x4_down: assert property (p_x4_down) // [R10]
		else $error("times-four mode missed down count");

	property p_shot_hold;
		@(posedge clk_sys) disable iff (sys_rst)
		(state_reg == ST_RUN && shotMode && startFlag && !trig && !tick)
			|=> $stable(cnt_reg);
	endproperty
	a_shot_hold: assert property (p_shot_hold) // [R21]
		else $error("one-shot count moved without a tick");

	c_wrap: cover property (@(posedge clk_sys) disable iff (sys_rst) wrap);
	c_shot: cover property (@(posedge clk_sys) disable iff (sys_rst)
		shotEnd ##1 irqReq);
	c_retrig: cover property (@(posedge clk_sys) disable iff (sys_rst)
		(state_reg == ST_RUN) && trig);
	c_x4_rev: cover property (@(posedge clk_sys) disable iff (sys_rst)
		(state_reg == ST_EVENT) && x4Mode && revStep);

endmodule : tqo_timer

//--- bench/tqo_encoder.sv
// Two-phase encoder model that drives the timer's pin pair.
// Assumes one-cycle step requests on clk_sys; pins are always driven.
`timescale 1ns/1ps

module tqo_encoder (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic sys_rst,
	// Step requests
	input  wire logic stepUp,
	input  wire logic stepDn,
	// Encoder phases
	output logic      phaseA,
	output logic      phaseB
);
	// ********************************
	// Gray-code position
	// ********************************
	logic [1:0] pos_reg;

	// Forward order {A,B}: 00, 01, 11, 10
	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			pos_reg <= 2'h0;
		else if (stepUp)
			pos_reg <= pos_reg + 2'h1;
		else if (stepDn)
			pos_reg <= pos_reg - 2'h1;
	end

	// Only one pin moves per step
	assign phaseA = pos_reg[1];
	assign phaseB = pos_reg[1] ^ pos_reg[0];
endmodule : tqo_encoder

//--- bench/tb_top.sv
// Self-checking bench for the two-phase / one-shot timer channel.
// Assumes the encoder model on the pins and a 20 MHz clk_sys.
`timescale 1ns/1ps

module tb_top
	import tqo_pkg::*;
;
	// ********************************
	// Signals
	// ********************************
	logic        clk_sys, sys_rst, regWr, regRd, otherOvf, irqReq;
	logic        encA, encB, pinOut, pinOe, stepUp, stepDn, x4, run, up;
	logic [3:0]  regAddr;
	logic [15:0] regWdata, regRdata, rdVal, expCnt, rel, n;
	logic [31:0] seed, r;
	int          n_fail, compares, irqCnt, hiCnt, i0, dv;
	wire         pinB;

	// Pin B resolved from both drivers
	assign pinB = pinOe ? pinOut : encB;

	tqo_timer #(.CHANNEL(2)) u_tqo_timer (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .otherOvf(otherOvf), .timerInputPin(encA),
		.timerOutputPinIn(pinB), .timerOutputPinOut(pinOut),
		.timerOutputPinOe(pinOe), .irqReq(irqReq)
	);

	tqo_encoder u_tqo_encoder (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .stepUp(stepUp),
		.stepDn(stepDn), .phaseA(encA), .phaseB(encB)
	);

	// Clock and event monitors
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		if (irqReq === 1'b1)
			irqCnt++;
		if (pinOe === 1'b1 && pinOut === 1'b1)
			hiCnt++;
	end

	// ********************************
	// Helpers
	// ********************************
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	// Step direction: 1 up, 2 down, 0 none
	function automatic logic [1:0] qd(input logic [1:0] o, input logic [1:0] p, input logic u);
		if (x4)
			return u ? 2'h1 : 2'h2;
		if (!p[0] || o[1] == p[1])
			return 2'h0;
		return p[1] ? 2'h1 : 2'h2;
	endfunction : qd

	// Counter after one step, reload on wrap
	function automatic logic [15:0] nxt(input logic [15:0] c, input logic [1:0] d);
		if (d == 2'h1)
			return (c == CNT_MAX) ? rel : c + 16'h0001;
		if (d == 2'h2)
			return (c == CNT_ZERO) ? rel : c - 16'h0001;
		return c;
	endfunction : nxt

	function automatic logic [15:0] okw(input int w, input int lo, input int hi);
		return {15'h0000, w >= lo && w <= hi};
	endfunction : okw

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk_sys);
		regWr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a);
		@(posedge clk_sys);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk_sys);
		regRd <= 1'b0;
		#1 rdVal = regRdata;
	endtask : rd

	task automatic step(input logic u);
		logic [1:0] o;
		o = {encA, encB};
		@(posedge clk_sys);
		stepUp <= u;
		stepDn <= !u;
		@(posedge clk_sys);
		stepUp <= 1'b0;
		stepDn <= 1'b0;
		#1;
		if (run)
			expCnt = nxt(expCnt, qd(o, {encA, encB}, u));
		repeat (6) @(posedge clk_sys);
	endtask : step

	task automatic arm(input logic [15:0] c, input logic [15:0] v);
		wr(ADDR_CTRL, c);
		wr(ADDR_TIMER, v);
		hiCnt = 0;
		i0 = irqCnt;
	endtask : arm

	// Start a one-shot: 0 software, 1 pin edge, 2 other timer
	task automatic kick(input logic [15:0] c, input int how);
		case (how)
			0: wr(ADDR_CTRL, c | 16'h0002);
			1: repeat (4) step(1'b1);
			default: begin
				@(posedge clk_sys);
				otherOvf <= 1'b1;
				@(posedge clk_sys);
				otherOvf <= 1'b0;
			end
		endcase
	endtask : kick

	task automatic conclude();
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : conclude

	// ********************************
	// Sequence
	// ********************************
	initial begin
		{regWr, regRd, otherOvf, stepUp, stepDn, x4, run} = 7'h00;
		regAddr = 4'h0;
		regWdata = 16'h0000;
		seed = 32'h0000_924E;
		sys_rst = 1'b1;
		repeat (6) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rd(ADDR_CTRL);
		chk(rdVal, {5'h00, CTRL_RESET});
		rd(4'h2);
		chk(rdVal, 16'h0000);
		// Two-phase: normal, then times four
		for (int m = 0; m < 2; m++) begin
			x4 = m[0];
			r = rnd();
			up = r[16];
			repeat (4) step(up);
			rel = r[15:0];
			expCnt = rel;
			wr(ADDR_TIMER, rel);
			rd(ADDR_TIMER);
			chk(rdVal, rel);
			wr(ADDR_CTRL, {12'h000, x4, 3'h1});
			run = 1'b1;
			// Times four: 16 steps one way, then 8 back
			for (int k = 0; k < 24; k++) begin
				r = rnd();
				step(x4 ? (up ^ (k >= 16)) : r[0]);
			end
			rd(ADDR_TIMER);
			chk(rdVal, expCnt);
			wr(ADDR_CTRL, {12'h000, x4, 3'h0});
			run = 1'b0;
			repeat (4) step(!up);
			rd(ADDR_TIMER);
			chk(rdVal, expCnt);
		end
		// Underflow then overflow with reload set while counting
		for (int d = 0; d < 2; d++) begin
			repeat (4) step(d[0]);
			expCnt = d ? CNT_MAX : CNT_ZERO;
			wr(ADDR_TIMER, expCnt);
			wr(ADDR_CTRL, 16'h0009);
			run = 1'b1;
			r = rnd();
			rel = r[15:0];
			wr(ADDR_TIMER, rel);
			rd(ADDR_TIMER);
			chk(rdVal, expCnt);
			i0 = irqCnt;
			step(d[0]);
			rd(ADDR_TIMER);
			chk(rdVal, expCnt);
			chk(16'(irqCnt - i0), 16'h0001);
			wr(ADDR_CTRL, 16'h0008);
			run = 1'b0;
		end
		// One-shot on each count source
		for (int s = 0; s < 3; s++) begin
			r = rnd();
			n = {12'h000, r[3:0]} + 16'h0002;
			dv = (s == 0) ? 1 : (s == 1) ? 8 : 32;
			arm({8'h02, s[1:0], 6'h05}, n);
			kick({8'h02, s[1:0], 6'h05}, 0);
			repeat (20 * dv + 20) @(posedge clk_sys);
			chk(okw(hiCnt, (n - 1) * dv, n * dv), 16'h0001);
			chk(16'(irqCnt - i0), 16'h0001);
			rd(ADDR_STATUS);
			chk(rdVal, 16'h0002);
			rd(ADDR_TIMER);
			chk(rdVal, n);
		end
		// Retrigger while running, then abort
		arm(16'h0205, 16'h0014);
		kick(16'h0205, 0);
		repeat (8) @(posedge clk_sys);
		kick(16'h0205, 0);
		repeat (60) @(posedge clk_sys);
		chk(okw(hiCnt, 29, 40), 16'h0001);
		chk(16'(irqCnt - i0), 16'h0001);
		arm(16'h0205, 16'h0014);
		kick(16'h0205, 0);
		repeat (8) @(posedge clk_sys);
		wr(ADDR_CTRL, 16'h0204);
		repeat (40) @(posedge clk_sys);
		chk(okw(hiCnt, 8, 13), 16'h0001);
		chk(16'(irqCnt - i0), 16'h0000);
		// Pin rise, other timer, then pin fall trigger
		for (int t = 1; t < 4; t++) begin
			arm(t == 1 ? 16'h0315 : t == 2 ? 16'h0225 : 16'h0715, 16'h0006);
			kick(16'h0000, (t == 3) ? 1 : t);
			repeat (20) @(posedge clk_sys);
			chk(okw(hiCnt, 5, 6), 16'h0001);
			chk(16'(irqCnt - i0), 16'h0001);
		end
		// Both pins as general ports
		wr(ADDR_CTRL, 16'h0004);
		wr(ADDR_PORT, 16'h0003);
		repeat (4) @(posedge clk_sys);
		rd(ADDR_PORT);
		chk(rdVal, {12'h000, 3'h7, encA});
		chk({14'h0000, pinOe, pinOut}, 16'h0003);
		conclude();
	end

	// Watchdog well beyond the expected run
	initial begin
		n_fail = 0;
		compares = 0;
		irqCnt = 0;
		hiCnt = 0;
		repeat (40000) @(posedge clk_sys);
		n_fail++;
		conclude();
	end
endmodule : tb_top
